// ==== design/ob_xfer_pkg.sv ====
// constants and types shared by the output buffer transfer logic
//
// Notes on behaviour
// - swap also exchanges host and shadow masks
// - host mask: bit 17 data, bit 16 header
// - shadow mask: bit 1 data, bit 0 header
// - header copied clears buffer status-update flag
// - data copied clears buffer new-data flag
// - request bit 9 starts copy into shadow
// - request accepted only while not busy
// - busy bit 15 set on accept, cleared after copy
// - swap bit 8 exchanges banks when not busy
// - request write while busy flags error, changes nothing
// - bits 22..16 show buffer held by host bank
// - fifo first number redirects to get index
// - host bank readable while shadow fills
package ob_xfer_pkg;

  localparam int HDR_WORDS = 3;
  localparam int DATA_WORDS = 64;
  localparam int BUF_WORDS = HDR_WORDS + DATA_WORDS;

  localparam logic [6:0] HDR_LAST = 7'h02;
  localparam logic [6:0] DATA_FIRST = 7'h03;
  localparam logic [6:0] DATA_LAST = 7'h42;

  localparam int MASK_HOST_DATA_BIT = 17;
  localparam int MASK_HOST_HDR_BIT = 16;
  localparam int MASK_SHD_DATA_BIT = 1;
  localparam int MASK_SHD_HDR_BIT = 0;

  localparam int REQ_HOST_NUM_LSB = 16;
  localparam int REQ_HOST_NUM_MSB = 22;
  localparam int REQ_BUSY_BIT = 15;
  localparam int REQ_START_BIT = 9;
  localparam int REQ_SWAP_BIT = 8;
  localparam int REQ_SEL_MSB = 6;

  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] REQ_RESET = 32'h0000_0000;
  localparam logic [6:0] NUM_RESET = 7'h00;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_HDR = 2'b01,
    SEQ_DATA = 2'b11,
    SEQ_FIN = 2'b10
  } seq_state_t;

endpackage

// ==== design/ob_bank_store.sv ====
// two-bank output buffer storage: shadow bank filled, host bank read
`timescale 1ns/1ps
`default_nettype none

module ob_bank_store (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic swap_i,
  input wire logic wr_i,
  input wire logic [6:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [6:0] rd_addr_i,
  output logic [31:0] rd_data_o
);

  logic [31:0] mem [0:1][0:ob_xfer_pkg::BUF_WORDS-1];
  logic shadow_idx;
  logic next_shadow_idx;
  logic [31:0] next_rd_data;

  always_comb begin
    next_shadow_idx = shadow_idx ^ swap_i;
    next_rd_data = 32'h0000_0000;
    // host side reads the other bank, so it never sees a half-filled copy
    if (rd_addr_i <= ob_xfer_pkg::DATA_LAST) begin
      next_rd_data = mem[~shadow_idx][rd_addr_i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shadow_idx <= 1'b0;
      rd_data_o <= 32'h0000_0000;
    end else begin
      shadow_idx <= next_shadow_idx;
      rd_data_o <= next_rd_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_i && wr_addr_i <= ob_xfer_pkg::DATA_LAST) begin
      mem[shadow_idx][wr_addr_i] <= wr_data_i;
    end
  end

endmodule

`default_nettype wire

// ==== design/ob_copy_seq.sv ====
// copy sequencer: fetches header then data words of one buffer
`timescale 1ns/1ps
`default_nettype none

module ob_copy_seq (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [6:0] buf_i,
  input wire logic hdr_en_i,
  input wire logic data_en_i,
  output logic ram_rd_o,
  output logic [6:0] ram_buf_o,
  output logic [6:0] ram_word_o,
  input wire logic ram_ack_i,
  input wire logic [31:0] ram_data_i,
  output logic wr_o,
  output logic [6:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic hdr_done_o,
  output logic data_done_o,
  output logic fin_o
);

  ob_xfer_pkg::seq_state_t state, next_state;
  logic [6:0] next_buf, next_word;
  logic data_en, next_data_en;
  logic next_wr, next_hdr_done, next_data_done;
  logic [6:0] next_wr_addr;
  logic [31:0] next_wr_data;

  assign ram_rd_o = (state == ob_xfer_pkg::SEQ_HDR) || (state == ob_xfer_pkg::SEQ_DATA);
  assign fin_o = (state == ob_xfer_pkg::SEQ_FIN);

  always_comb begin
    next_state = state;
    next_buf = ram_buf_o;
    next_word = ram_word_o;
    next_data_en = data_en;
    next_wr = ram_rd_o && ram_ack_i;
    next_wr_addr = ram_word_o;
    next_wr_data = ram_data_i;
    next_hdr_done = 1'b0;
    next_data_done = 1'b0;
    unique case (state)
      ob_xfer_pkg::SEQ_IDLE: begin
        if (start_i) begin
          next_buf = buf_i;
          next_data_en = data_en_i;
          if (hdr_en_i) begin
            next_state = ob_xfer_pkg::SEQ_HDR;
            next_word = 7'h00;
          end else if (data_en_i) begin
            next_state = ob_xfer_pkg::SEQ_DATA;
            next_word = ob_xfer_pkg::DATA_FIRST;
          end else begin
            next_state = ob_xfer_pkg::SEQ_FIN;
          end
        end
      end
      ob_xfer_pkg::SEQ_HDR: begin
        if (ram_ack_i) begin
          next_word = ram_word_o + 7'h01;
          if (ram_word_o == ob_xfer_pkg::HDR_LAST) begin
            next_hdr_done = 1'b1;
            next_state = data_en ? ob_xfer_pkg::SEQ_DATA : ob_xfer_pkg::SEQ_FIN;
          end
        end
      end
      ob_xfer_pkg::SEQ_DATA: begin
        if (ram_ack_i) begin
          next_word = ram_word_o + 7'h01;
          if (ram_word_o == ob_xfer_pkg::DATA_LAST) begin
            next_data_done = 1'b1;
            next_state = ob_xfer_pkg::SEQ_FIN;
          end
        end
      end
      ob_xfer_pkg::SEQ_FIN: begin
        next_state = ob_xfer_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= ob_xfer_pkg::SEQ_IDLE;
      ram_buf_o <= ob_xfer_pkg::NUM_RESET;
      ram_word_o <= 7'h00;
      data_en <= 1'b0;
      wr_o <= 1'b0;
      wr_addr_o <= 7'h00;
      wr_data_o <= 32'h0000_0000;
      hdr_done_o <= 1'b0;
      data_done_o <= 1'b0;
    end else begin
      state <= next_state;
      ram_buf_o <= next_buf;
      ram_word_o <= next_word;
      data_en <= next_data_en;
      wr_o <= next_wr;
      wr_addr_o <= next_wr_addr;
      wr_data_o <= next_wr_data;
      hdr_done_o <= next_hdr_done;
      data_done_o <= next_data_done;
    end
  end

endmodule

`default_nettype wire

// ==== design/output_buffer_transfer_ctrl.sv ====
// output buffer control registers, transfer start, bank swap, flag clears
`timescale 1ns/1ps
`default_nettype none

module output_buffer_transfer_ctrl (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic mask_wr_i,
  input wire logic req_wr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] mask_rdata_o,
  output logic [31:0] req_rdata_o,
  input wire logic [6:0] host_rd_addr_i,
  output logic [31:0] host_rd_data_o,
  input wire logic [6:0] fifo_first_i,
  input wire logic [6:0] fifo_get_index_i,
  output logic ram_rd_o,
  output logic [6:0] ram_buf_o,
  output logic [6:0] ram_word_o,
  input wire logic ram_ack_i,
  input wire logic [31:0] ram_data_i,
  output logic status_clr_o,
  output logic [6:0] status_clr_num_o,
  output logic new_data_clr_o,
  output logic [6:0] new_data_clr_num_o,
  output logic access_err_o
);

  logic host_hdr_sel, host_data_sel;
  logic shadow_hdr_sel, shadow_data_sel;
  logic next_host_hdr_sel, next_host_data_sel;
  logic next_shadow_hdr_sel, next_shadow_data_sel;
  logic [6:0] shadow_select_number, next_shadow_select_number;
  logic [6:0] host_buffer_number, next_host_buffer_number;
  logic [6:0] xfer_num, next_xfer_num;
  logic shadow_busy, next_shadow_busy;
  logic next_status_clr, next_new_data_clr, next_access_err;
  logic accept, swap, start_hdr, start_data;
  logic [6:0] start_num;
  logic seq_wr, seq_hdr_done, seq_data_done, seq_fin;
  logic [6:0] seq_wr_addr;
  logic [31:0] seq_wr_data;

  // a select equal to the fifo's first buffer means "next fifo entry"
  function automatic logic [6:0] resolve_num(input logic [6:0] sel,
                                             input logic [6:0] first,
                                             input logic [6:0] fifo_get_index);
    resolve_num = (sel == first) ? fifo_get_index : sel;
  endfunction

  assign accept = req_wr_i && !shadow_busy && wdata_i[ob_xfer_pkg::REQ_START_BIT];
  assign swap = req_wr_i && !shadow_busy && wdata_i[ob_xfer_pkg::REQ_SWAP_BIT];

  always_comb begin
    next_host_hdr_sel = host_hdr_sel;
    next_host_data_sel = host_data_sel;
    next_shadow_hdr_sel = shadow_hdr_sel;
    next_shadow_data_sel = shadow_data_sel;
    if (mask_wr_i) begin
      next_host_data_sel = wdata_i[ob_xfer_pkg::MASK_HOST_DATA_BIT];
      next_host_hdr_sel = wdata_i[ob_xfer_pkg::MASK_HOST_HDR_BIT];
      next_shadow_data_sel = wdata_i[ob_xfer_pkg::MASK_SHD_DATA_BIT];
      next_shadow_hdr_sel = wdata_i[ob_xfer_pkg::MASK_SHD_HDR_BIT];
    end
    if (swap) begin
      next_host_data_sel = shadow_data_sel;
      next_host_hdr_sel = shadow_hdr_sel;
      next_shadow_data_sel = host_data_sel;
      next_shadow_hdr_sel = host_hdr_sel;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      host_hdr_sel <= ob_xfer_pkg::MASK_RESET[ob_xfer_pkg::MASK_HOST_HDR_BIT];
      host_data_sel <= ob_xfer_pkg::MASK_RESET[ob_xfer_pkg::MASK_HOST_DATA_BIT];
      shadow_hdr_sel <= ob_xfer_pkg::MASK_RESET[ob_xfer_pkg::MASK_SHD_HDR_BIT];
      shadow_data_sel <= ob_xfer_pkg::MASK_RESET[ob_xfer_pkg::MASK_SHD_DATA_BIT];
    end else begin
      host_hdr_sel <= next_host_hdr_sel;
      host_data_sel <= next_host_data_sel;
      shadow_hdr_sel <= next_shadow_hdr_sel;
      shadow_data_sel <= next_shadow_data_sel;
    end
  end

  // the written select is used at once, so one write both loads and starts;
  // taking it from the bus keeps the start path clear of the register update
  assign start_num = resolve_num(wdata_i[ob_xfer_pkg::REQ_SEL_MSB:0], fifo_first_i,
                                 fifo_get_index_i);
  assign start_hdr = next_shadow_hdr_sel;
  assign start_data = next_shadow_data_sel;

  always_comb begin
    next_shadow_select_number = shadow_select_number;
    next_host_buffer_number = host_buffer_number;
    next_xfer_num = xfer_num;
    next_shadow_busy = shadow_busy;
    next_access_err = 1'b0;
    if (req_wr_i && shadow_busy) begin
      next_access_err = 1'b1;
    end else if (req_wr_i) begin
      next_shadow_select_number = wdata_i[ob_xfer_pkg::REQ_SEL_MSB:0];
    end
    if (swap) begin
      next_host_buffer_number = xfer_num;
    end
    if (accept) begin
      next_xfer_num = start_num;
    end
    if (accept) begin
      next_shadow_busy = 1'b1;
    end else if (seq_fin) begin
      next_shadow_busy = 1'b0;
    end
    next_status_clr = seq_hdr_done;
    next_new_data_clr = seq_data_done;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shadow_select_number <= ob_xfer_pkg::NUM_RESET;
      host_buffer_number <= ob_xfer_pkg::NUM_RESET;
      xfer_num <= ob_xfer_pkg::NUM_RESET;
      shadow_busy <= 1'b0;
      access_err_o <= 1'b0;
      status_clr_o <= 1'b0;
      new_data_clr_o <= 1'b0;
    end else begin
      shadow_select_number <= next_shadow_select_number;
      host_buffer_number <= next_host_buffer_number;
      xfer_num <= next_xfer_num;
      shadow_busy <= next_shadow_busy;
      access_err_o <= next_access_err;
      status_clr_o <= next_status_clr;
      new_data_clr_o <= next_new_data_clr;
    end
  end

  // the number is stable for the whole transfer, so flops can be shared
  assign status_clr_num_o = xfer_num;
  assign new_data_clr_num_o = xfer_num;

  always_comb begin
    mask_rdata_o = 32'h0000_0000;
    mask_rdata_o[ob_xfer_pkg::MASK_HOST_DATA_BIT] = host_data_sel;
    mask_rdata_o[ob_xfer_pkg::MASK_HOST_HDR_BIT] = host_hdr_sel;
    mask_rdata_o[ob_xfer_pkg::MASK_SHD_DATA_BIT] = shadow_data_sel;
    mask_rdata_o[ob_xfer_pkg::MASK_SHD_HDR_BIT] = shadow_hdr_sel;
    req_rdata_o = 32'h0000_0000;
    req_rdata_o[ob_xfer_pkg::REQ_HOST_NUM_MSB:ob_xfer_pkg::REQ_HOST_NUM_LSB] = host_buffer_number;
    req_rdata_o[ob_xfer_pkg::REQ_BUSY_BIT] = shadow_busy;
    req_rdata_o[ob_xfer_pkg::REQ_SEL_MSB:0] = shadow_select_number;
  end

  ob_copy_seq u_seq (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .start_i(accept),
    .buf_i(start_num),
    .hdr_en_i(start_hdr),
    .data_en_i(start_data),
    .ram_rd_o(ram_rd_o),
    .ram_buf_o(ram_buf_o),
    .ram_word_o(ram_word_o),
    .ram_ack_i(ram_ack_i),
    .ram_data_i(ram_data_i),
    .wr_o(seq_wr),
    .wr_addr_o(seq_wr_addr),
    .wr_data_o(seq_wr_data),
    .hdr_done_o(seq_hdr_done),
    .data_done_o(seq_data_done),
    .fin_o(seq_fin)
  );

  ob_bank_store u_store (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .swap_i(swap),
    .wr_i(seq_wr),
    .wr_addr_i(seq_wr_addr),
    .wr_data_i(seq_wr_data),
    .rd_addr_i(host_rd_addr_i),
    .rd_data_o(host_rd_data_o)
  );

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence accept_s;
    req_wr_i && !shadow_busy && wdata_i[ob_xfer_pkg::REQ_START_BIT];
  endsequence

  sequence swap_s;
    req_wr_i && !shadow_busy && wdata_i[ob_xfer_pkg::REQ_SWAP_BIT];
  endsequence

  sequence busy_write_s;
    req_wr_i && shadow_busy;
  endsequence

  sequence word_taken_s;
    ram_rd_o && ram_ack_i;
  endsequence

  swap_mask_a: assert property (
    swap_s |=> host_data_sel == $past(shadow_data_sel)
      && shadow_hdr_sel == $past(host_hdr_sel))
    else $error("masks not exchanged on swap");

  mask_bits_a: assert property (
    mask_wr_i && !swap |=> mask_rdata_o[17:16] == $past(wdata_i[17:16]))
    else $error("host mask bits misplaced");

  shadow_bits_a: assert property (
    mask_wr_i && !swap |=> mask_rdata_o[1:0] == $past(wdata_i[1:0]))
    else $error("shadow mask bits misplaced");

  hdr_clear_a: assert property (
    seq_hdr_done |=> status_clr_o && status_clr_num_o == $past(ram_buf_o))
    else $error("status flag clear missing");

  data_clear_a: assert property (
    seq_data_done |=> new_data_clr_o && !status_clr_o
      && new_data_clr_num_o == $past(ram_buf_o))
    else $error("new data clear missing");

  start_copy_a: assert property (
    accept_s |=> (ram_rd_o && ram_buf_o == xfer_num) || seq_fin)
    else $error("transfer not started");

  busy_refuse_a: assert property (
    busy_write_s and (!seq_fin) |=> $stable(shadow_select_number) && $stable(xfer_num)
      && shadow_busy)
    else $error("request taken while busy");

  busy_set_a: assert property (
    accept_s |=> shadow_busy && req_rdata_o[15])
    else $error("busy not set on accept");

  busy_clear_a: assert property (
    seq_fin |=> !shadow_busy ##1 (!ram_rd_o || $past(accept)))
    else $error("busy not cleared at end");

  swap_guard_a: assert property (
    busy_write_s and (!mask_wr_i) |=> $stable(host_buffer_number) && $stable(host_data_sel))
    else $error("swap taken while busy");

  access_err_a: assert property (
    (busy_write_s |=> access_err_o) and
    (!req_wr_i |=> !access_err_o))
    else $error("access error flag wrong");

  host_num_a: assert property (
    swap_s |=> req_rdata_o[22:16] == $past(xfer_num))
    else $error("host number not updated");

  fifo_redir_a: assert property (
    accept_s and (next_shadow_select_number == fifo_first_i)
      |=> xfer_num == $past(fifo_get_index_i))
    else $error("fifo redirect not applied");

  zero_bits_a: assert property (
    req_rdata_o[31:23] == 9'h000 && req_rdata_o[14:7] == 8'h00
      && mask_rdata_o[31:18] == 14'h0000 && mask_rdata_o[15:2] == 14'h0000)
    else $error("unused bits not zero");

  word_step_a: assert property (
    word_taken_s and (ram_word_o != ob_xfer_pkg::HDR_LAST)
      and (ram_word_o != ob_xfer_pkg::DATA_LAST)
      |=> ram_rd_o && ram_word_o == $past(ram_word_o) + 7'h01)
    else $error("word index did not advance");

  req_hold_a: assert property (
    ram_rd_o && !ram_ack_i |=> ram_rd_o && $stable(ram_word_o) && $stable(ram_buf_o))
    else $error("ram request dropped before answer");

  idle_quiet_a: assert property (
    !shadow_busy |-> !ram_rd_o)
    else $error("ram read while not busy");

  clr_pulse_a: assert property (
    status_clr_o |=> !status_clr_o)
    else $error("status clear longer than a pulse");

  xfer_hold_a: assert property (
    shadow_busy |=> $stable(xfer_num))
    else $error("buffer number moved during copy");

endmodule

`default_nettype wire

// ==== bench/msg_ram_model.sv ====
// message ram stand-in that answers the copy sequencer after a set wait
`timescale 1ns/1ps
`default_nettype none

module msg_ram_model (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] wait_i,
  input wire logic ram_rd_i,
  input wire logic [6:0] ram_buf_i,
  input wire logic [6:0] ram_word_i,
  output logic ram_ack_o,
  output logic [31:0] ram_data_o
);
  logic [3:0] cnt;
  logic [31:0] last;

  assign ram_ack_o = ram_rd_i && (cnt == wait_i);
  // off the ack the data lines flip every cycle, so a stale word never looks valid
  assign ram_data_o = ram_ack_o ? {8'h5a, 1'b0, ram_buf_i, 1'b0, ram_word_i, 8'h3c} : ~last;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !ram_rd_i || ram_ack_o) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
    last <= srst_i ? 32'h0 : ram_data_o;
  end
endmodule

`default_nettype wire

// ==== bench/output_buffer_transfer_ctrl_tb_top.sv ====
// self-checking bench for the output buffer transfer control block
`timescale 1ns/1ps
`default_nettype none

module output_buffer_transfer_ctrl_tb_top;
  logic sys_clk_i, srst_i, mask_wr_i, req_wr_i, ram_rd_o, ram_ack_i;
  logic status_clr_o, new_data_clr_o, access_err_o;
  logic [31:0] wdata_i, mask_rdata_o, req_rdata_o, host_rd_data_o, ram_data_i;
  logic [6:0] host_rd_addr_i, fifo_first_i, fifo_get_index_i, ram_buf_o, ram_word_o;
  logic [6:0] status_clr_num_o, new_data_clr_num_o, exp_buf, st_num, nd_num;
  logic [3:0] wait_cyc;
  int bad_count, compares, st_n, nd_n, err_n, rd_n;

  output_buffer_transfer_ctrl dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .mask_wr_i(mask_wr_i), .req_wr_i(req_wr_i),
    .wdata_i(wdata_i), .mask_rdata_o(mask_rdata_o), .req_rdata_o(req_rdata_o),
    .host_rd_addr_i(host_rd_addr_i), .host_rd_data_o(host_rd_data_o),
    .fifo_first_i(fifo_first_i), .fifo_get_index_i(fifo_get_index_i),
    .ram_rd_o(ram_rd_o), .ram_buf_o(ram_buf_o), .ram_word_o(ram_word_o),
    .ram_ack_i(ram_ack_i), .ram_data_i(ram_data_i), .status_clr_o(status_clr_o),
    .status_clr_num_o(status_clr_num_o), .new_data_clr_o(new_data_clr_o),
    .new_data_clr_num_o(new_data_clr_num_o), .access_err_o(access_err_o)
  );

  msg_ram_model ram (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wait_i(wait_cyc), .ram_rd_i(ram_rd_o),
    .ram_buf_i(ram_buf_o), .ram_word_i(ram_word_o), .ram_ack_o(ram_ack_i),
    .ram_data_o(ram_data_i)
  );

  function automatic logic [31:0] pat(input logic [6:0] b, input logic [6:0] w);
    return {8'h5a, 1'b0, b, 1'b0, w, 8'h3c};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic is_req, input logic [31:0] d);
    @(posedge sys_clk_i);
    mask_wr_i <= !is_req;
    req_wr_i <= is_req;
    wdata_i <= d;
    @(posedge sys_clk_i);
    mask_wr_i <= 1'b0;
    req_wr_i <= 1'b0;
    #1;
  endtask

  // bounded wait for the shadow fill to finish, then let the clear pulses land
  task automatic wait_idle();
    int n;
    n = 0;
    while (req_rdata_o[15] !== 1'b0 && n < 2000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("busy drop", 32'h0, {31'h0, req_rdata_o[15]});
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic hr(input logic [6:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    host_rd_addr_i <= a;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("host word", exp, host_rd_data_o);
  endtask

  task automatic clr_counts();
    st_n = 0;
    nd_n = 0;
    err_n = 0;
    rd_n = 0;
  endtask

  always @(posedge sys_clk_i) begin
    if (status_clr_o === 1'b1) begin
      st_n++;
      st_num = status_clr_num_o;
    end
    if (new_data_clr_o === 1'b1) begin
      nd_n++;
      nd_num = new_data_clr_num_o;
    end
    if (access_err_o === 1'b1) begin
      err_n++;
    end
    if (ram_rd_o === 1'b1 && ram_ack_i === 1'b1) begin
      rd_n++;
      chk("ram buffer", {25'h0, exp_buf}, {25'h0, ram_buf_o});
    end
  end

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // the whole sequence needs a few hundred cycles; this allows about fifty thousand
  initial begin
    #250000;
    bad_count++;
    results();
  end

  initial begin
    srst_i = 1'b1;
    mask_wr_i = 1'b0;
    req_wr_i = 1'b0;
    wdata_i = 32'h0;
    host_rd_addr_i = 7'h00;
    fifo_first_i = 7'h0a;
    fifo_get_index_i = 7'h14;
    wait_cyc = 4'h3;
    exp_buf = 7'h05;
    clr_counts();
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    #1;
    chk("mask reset", 32'h0, mask_rdata_o);
    chk("req reset", 32'h0, req_rdata_o);
    wr(1'b0, 32'hffff_ffff);
    chk("mask bits", 32'h0003_0003, mask_rdata_o);
    wr(1'b1, 32'hffff_fc7f);
    chk("req bits", 32'h0000_007f, req_rdata_o);
    $display("test registers done");

    clr_counts();
    wr(1'b0, 32'h0000_0003);
    wr(1'b1, 32'h0000_0205);
    chk("busy set", 32'h1, {31'h0, req_rdata_o[15]});
    wr(1'b1, 32'h0000_0309);
    chk("sel kept", 32'h5, {25'h0, req_rdata_o[6:0]});
    wait_idle();
    chk("refusals", 32'h1, err_n);
    chk("ram reads", 32'd67, rd_n);
    chk("status clears", 32'h1, st_n);
    chk("status num", 32'h5, {25'h0, st_num});
    chk("data clears", 32'h1, nd_n);
    chk("data num", 32'h5, {25'h0, nd_num});
    $display("test transfer done");

    wr(1'b1, 32'h0000_0105);
    chk("host num", 32'h0005_0005, req_rdata_o);
    chk("mask swap", 32'h0003_0000, mask_rdata_o);
    hr(7'h00, pat(7'h05, 7'h00));
    hr(7'h02, pat(7'h05, 7'h02));
    hr(7'h42, pat(7'h05, 7'h42));
    hr(7'h43, 32'h0);
    $display("test swap done");

    clr_counts();
    wait_cyc = 4'h8;
    exp_buf = 7'h07;
    wr(1'b0, 32'h0000_0001);
    wr(1'b1, 32'h0000_0207);
    wr(1'b1, 32'h0000_0100);
    hr(7'h01, pat(7'h05, 7'h01));
    wait_idle();
    chk("host kept", 32'h0005_0007, req_rdata_o);
    chk("hdr reads", 32'd3, rd_n);
    chk("hdr clears", 32'h1, st_n);
    chk("no data clear", 32'h0, nd_n);
    chk("refusals 2", 32'h1, err_n);
    wr(1'b1, 32'h0000_0107);
    chk("host num 2", 32'h0007_0007, req_rdata_o);
    chk("mask swap 2", 32'h0001_0000, mask_rdata_o);
    hr(7'h00, pat(7'h07, 7'h00));
    $display("test overlap done");

    clr_counts();
    wait_cyc = 4'h0;
    exp_buf = 7'h14;
    wr(1'b0, 32'h0000_0002);
    wr(1'b1, 32'h0000_020a);
    wait_idle();
    chk("fifo reads", 32'd64, rd_n);
    chk("fifo clear num", 32'h14, {25'h0, nd_num});
    chk("no hdr clear", 32'h0, st_n);
    $display("test fifo done");

    clr_counts();
    wr(1'b0, 32'h0000_0000);
    wr(1'b1, 32'h0000_0203);
    wait_idle();
    chk("empty reads", 32'h0, rd_n);
    chk("empty clears", 32'h0, st_n + nd_n);
    $display("test empty done");

    clr_counts();
    exp_buf = 7'h06;
    wr(1'b0, 32'h0001_0000);
    wr(1'b1, 32'h0000_0306);
    chk("swap start", 32'h0003_8006, req_rdata_o);
    chk("mask swap 3", 32'h0000_0001, mask_rdata_o);
    wait_idle();
    chk("swap start reads", 32'd3, rd_n);
    chk("swap start num", 32'h6, {25'h0, st_num});
    $display("test swap start done");
    results();
  end
endmodule

`default_nettype wire
